// ---- src/tts_target.sv ----
`timescale 1ns/1ps
module tts_target
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // bus pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   scl_out,
  output logic                   scl_oe_out,
  output logic                   sda_out,
  output logic                   sda_oe_out,
  // software side
  input  wire logic              buf_wr_in,
  input  wire logic [BYTE_W-1:0] buf_wr_data_in,
  input  wire logic              buf_rd_in,
  input  wire logic              addr_wr_in,
  input  wire logic [BYTE_W-1:0] addr_wr_data_in,
  input  wire logic              clock_release_set_in,
  input  wire logic              irq_clr_in,
  input  wire logic              collision_clr_in,
  // configuration
  input  wire logic              ten_bit_en_in,
  input  wire logic              address_hold_en_in,
  input  wire logic              stretch_enable_in,
  input  wire logic              start_irq_en_in,
  input  wire logic              target_collision_detect_en_in,
  input  wire logic              ack_value_select_in,
  // status
  output logic [BYTE_W-1:0]      data_buffer_out,
  output logic [BYTE_W-1:0]      own_address_out,
  output logic                   clock_release_out,
  output logic                   port_irq_flag_out,
  output logic                   bus_collision_flag_out,
  output logic                   ack_received_status_out,
  output logic                   ack_time_indicator_out,
  output logic                   read_dir_out,
  output logic                   data_not_addr_out,
  output logic                   buffer_full_out,
  output logic                   update_address_flag_out,
  output logic                   start_seen_out
);

  // pin synchronisers and edge history
  logic              scl_meta_reg, scl_s_reg, scl_d_reg;
  logic              sda_meta_reg, sda_s_reg, sda_d_reg;
  // control state
  tts_state_t        st_reg;       // main state
  tts_stage_t        stage_reg;    // address phase
  logic [CNT_W-1:0]  cnt_reg;      // bit counter
  logic [BYTE_W-1:0] rx_reg;       // receive shift
  logic [BYTE_W-1:0] tx_shift_reg; // transmit shift
  logic              ack_low_reg;  // drive ack low in ST_ACK
  logic              ten_ok_reg;   // full 10-bit match seen
  logic              scl_oe_reg, sda_oe_reg;

  // bus events
  wire scl_rise  = scl_s_reg & ~scl_d_reg;
  wire scl_fall  = ~scl_s_reg & scl_d_reg;
  wire start_det = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
  wire stop_det  = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
  wire byte_done = (st_reg == ST_RX) & scl_fall & (cnt_reg == BITS_BYTE);
  // address compare
  wire hi_ten  = (rx_reg[PAT_HI:PAT_LO] == TEN_PATTERN)
               & (rx_reg[UPPER_HI:UPPER_LO] == own_address_out[UPPER_HI:UPPER_LO])
               & (~rx_reg[DIR_BIT] | ten_ok_reg);
  wire hi_sev  = rx_reg[ADDR7_HI:ADDR7_LO] == own_address_out[ADDR7_HI:ADDR7_LO];
  wire match_hi = ten_bit_en_in ? hi_ten : hi_sev;
  wire match_lo = rx_reg == own_address_out;
  wire is_read  = rx_reg[DIR_BIT];
  wire collide  = (st_reg == ST_TX) & scl_rise & tx_shift_reg[MSB] & ~sda_s_reg;
  // clock hold request: release clear or update pending
  wire hold_req = ~clock_release_out | update_address_flag_out;
  wire upd_due  = ten_bit_en_in & ~data_not_addr_out & ~read_dir_out;
  wire scl_oe_next = hold_req & (scl_oe_reg | ~scl_s_reg);
  wire sda_oe_next = (st_reg == ST_AHOLD) ? ~ack_value_select_in :
                     (st_reg == ST_ACK)   ? ack_low_reg :
                     (st_reg == ST_TX)    ? ~tx_shift_reg[MSB] : 1'b0;

  // two-stage pin synchronisers plus history stage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_meta_reg <= 1'b1;
      scl_s_reg    <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_s_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_s_reg    <= scl_meta_reg;
      scl_d_reg    <= scl_s_reg;
      sda_meta_reg <= sda_in;
      sda_s_reg    <= sda_meta_reg;
      sda_d_reg    <= sda_s_reg;
    end
  end

  // pin drivers, low level only
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end
  end
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;

  // main sequencer; software clears first so hardware sets win
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg                  <= ST_IDLE;
      stage_reg               <= STG_HIGH;
      cnt_reg                 <= CNT_ZERO;
      rx_reg                  <= BYTE_RST;
      tx_shift_reg            <= SHIFT_RST;
      ack_low_reg             <= 1'b0;
      ten_ok_reg              <= 1'b0;
      data_buffer_out         <= BYTE_RST;
      own_address_out         <= BYTE_RST;
      clock_release_out       <= 1'b1;
      port_irq_flag_out       <= 1'b0;
      bus_collision_flag_out  <= 1'b0;
      ack_received_status_out <= 1'b0;
      ack_time_indicator_out  <= 1'b0;
      read_dir_out            <= 1'b0;
      data_not_addr_out       <= 1'b0;
      buffer_full_out         <= 1'b0;
      update_address_flag_out <= 1'b0;
      start_seen_out          <= 1'b0;
    end else begin
      // software side effects
      if (irq_clr_in)           port_irq_flag_out      <= 1'b0;
      if (collision_clr_in)     bus_collision_flag_out <= 1'b0;
      if (buf_rd_in)            buffer_full_out        <= 1'b0;
      if (clock_release_set_in) clock_release_out      <= 1'b1;
      if (addr_wr_in) begin
        own_address_out         <= addr_wr_data_in;
        update_address_flag_out <= 1'b0;
      end
      if (buf_wr_in) begin
        data_buffer_out <= buf_wr_data_in;
        tx_shift_reg    <= buf_wr_data_in;
        buffer_full_out <= 1'b1;
      end
      // bus sequencing
      case (st_reg)
        ST_IDLE: cnt_reg <= CNT_ZERO;
        ST_RX: begin
          // sample on rising edges
          if (scl_rise) begin
            rx_reg  <= {rx_reg[MSB-1:0], sda_s_reg};
            cnt_reg <= cnt_reg + CNT_ONE;
          end
          if (byte_done) begin
            ack_low_reg <= 1'b1;
            case (stage_reg)
              STG_HIGH: begin
                if (match_hi) begin
                  data_buffer_out   <= rx_reg;
                  buffer_full_out   <= 1'b1;
                  read_dir_out      <= is_read;
                  data_not_addr_out <= 1'b0;
                  stage_reg <= (ten_bit_en_in & ~is_read) ? STG_LOW : STG_DATA;
                  if (address_hold_en_in) begin
                    clock_release_out      <= 1'b0;
                    port_irq_flag_out      <= 1'b1;
                    ack_time_indicator_out <= 1'b1;
                    st_reg                 <= ST_AHOLD;
                  end else begin
                    st_reg <= ST_ACK;
                  end
                end else begin
                  st_reg <= ST_IDLE;
                end
              end
              STG_LOW: begin
                // mismatch still runs the ninth clock, unanswered
                ack_low_reg <= match_lo;
                st_reg      <= ST_ACK;
                if (match_lo) begin
                  data_buffer_out <= rx_reg;
                  buffer_full_out <= 1'b1;
                  ten_ok_reg      <= 1'b1;
                  stage_reg       <= STG_DATA;
                end
              end
              default: begin
                data_buffer_out   <= rx_reg;
                buffer_full_out   <= 1'b1;
                data_not_addr_out <= 1'b1;
                st_reg            <= ST_ACK;
              end
            endcase
          end
        end
        ST_AHOLD: begin
          // software picks the answer, then releases the clock
          if (clock_release_out) begin
            ack_low_reg <= ~ack_value_select_in;
            st_reg      <= ST_ACK;
          end
        end
        ST_ACK: begin
          // ninth falling edge ends the acknowledge
          if (scl_fall) begin
            ack_time_indicator_out <= 1'b0;
            cnt_reg                <= CNT_ZERO;
            if (upd_due) update_address_flag_out <= 1'b1;
            if (ack_low_reg | upd_due) port_irq_flag_out <= 1'b1;
            if (!ack_low_reg) begin
              st_reg <= ST_IDLE;
            end else begin
              if (read_dir_out) begin
                clock_release_out <= 1'b0;
                st_reg            <= ST_TX;
              end else begin
                if ((stage_reg == STG_DATA) & data_not_addr_out & stretch_enable_in)
                  clock_release_out <= 1'b0;
                st_reg <= ST_RX;
              end
            end
          end
        end
        ST_TX: begin
          // shift on falling edges only
          if (scl_fall) begin
            if (cnt_reg == BITS_LAST) begin
              st_reg <= ST_TACK;
            end else begin
              tx_shift_reg <= {tx_shift_reg[MSB-1:0], 1'b1};
              cnt_reg      <= cnt_reg + CNT_ONE;
            end
          end
          if (collide & target_collision_detect_en_in) begin
            bus_collision_flag_out <= 1'b1;
            st_reg                 <= ST_IDLE;
          end
        end
        ST_TACK: begin
          if (scl_rise) ack_received_status_out <= sda_s_reg;
          if (scl_fall) begin
            port_irq_flag_out <= 1'b1;
            cnt_reg           <= CNT_ZERO;
            if (ack_received_status_out) begin
              st_reg <= ST_IDLE;
            end else begin
              clock_release_out <= 1'b0;
              st_reg            <= ST_TX;
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
      // start and stop override everything
      if (start_det) begin
        start_seen_out <= 1'b1;
        if (start_irq_en_in) port_irq_flag_out <= 1'b1;
        st_reg                 <= ST_RX;
        stage_reg              <= STG_HIGH;
        cnt_reg                <= CNT_ZERO;
        ack_time_indicator_out <= 1'b0;
      end else if (stop_det) begin
        start_seen_out <= 1'b0;
        ten_ok_reg     <= 1'b0;
        st_reg         <= ST_IDLE;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_start_seen_set: assert property (start_det |=> start_seen_out)
    else $error("start did not set start_seen");
  a_buffer_full_write: assert property (buf_wr_in |=> buffer_full_out)
    else $error("buffer write did not set buffer_full");
  a_shift_loaded: assert property (buf_wr_in && !(st_reg == ST_TX && scl_fall)
    |=> tx_shift_reg == $past(buf_wr_data_in))
    else $error("buffer write did not load shift register");
  a_ack_latch_rise: assert property (st_reg == ST_TACK && scl_rise && !start_det
    |=> ack_received_status_out == $past(sda_s_reg))
    else $error("acknowledge not latched on rising edge");
  a_nack_goes_idle: assert property (st_reg == ST_TACK && scl_fall
    && ack_received_status_out && !start_det |=> st_reg == ST_IDLE && port_irq_flag_out)
    else $error("not-acknowledge did not end read");
  a_read_stretch: assert property (st_reg == ST_ACK && scl_fall && ack_low_reg
    && read_dir_out && !clock_release_set_in |=> !clock_release_out ##1 scl_oe_reg)
    else $error("read address did not stretch clock");
  a_collision_idle: assert property (collide && target_collision_detect_en_in
    && !start_det && !stop_det |=> bus_collision_flag_out && st_reg == ST_IDLE)
    else $error("collision not flagged");
  a_update_holds: assert property (update_address_flag_out && scl_oe_reg
    && !addr_wr_in |=> scl_oe_reg)
    else $error("clock not held while update pending");
  a_release_frees: assert property ($rose(clock_release_out)
    && !update_address_flag_out |=> !scl_oe_reg)
    else $error("release did not free clock");
  a_hold_waits_low: assert property ($rose(scl_oe_reg) |-> $past(!scl_s_reg))
    else $error("clock driven before seen low");
  a_tx_fall_only: assert property (st_reg == ST_TX && !scl_fall && !buf_wr_in
    && $stable(st_reg) |=> ##1 $stable(sda_oe_reg))
    else $error("data changed outside falling edge");

endmodule : tts_target

// ---- src/tts_pkg.sv ----
package tts_pkg;
  // bit counts and widths
  localparam int          BYTE_W      = 8;
  localparam int          CNT_W       = 4;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [3:0]  BITS_LAST   = 4'h7;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  // first byte of a 10-bit address: pattern then two upper bits
  localparam logic [4:0]  TEN_PATTERN = 5'h1e;
  localparam int          PAT_HI      = 7;
  localparam int          PAT_LO      = 3;
  localparam int          UPPER_HI    = 2;
  localparam int          UPPER_LO    = 1;
  localparam int          ADDR7_HI    = 7;
  localparam int          ADDR7_LO    = 1;
  localparam int          DIR_BIT     = 0;
  localparam int          MSB         = 7;
  // reset values
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  SHIFT_RST   = 8'hff;
  // address phase of the transfer
  typedef enum logic [1:0] {
    STG_HIGH = 2'b00,  // first address byte
    STG_LOW  = 2'b01,  // 10-bit low address byte
    STG_DATA = 2'b10   // data bytes
  } tts_stage_t;
  // target state machine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,  // ignore bus until start
    ST_RX    = 3'b001,  // clocking a byte in
    ST_AHOLD = 3'b010,  // address hold, waiting for software
    ST_ACK   = 3'b011,  // driving the ninth bit
    ST_TX    = 3'b100,  // shifting read data out
    ST_TACK  = 3'b101   // sampling controller acknowledge
  } tts_state_t;
endpackage : tts_pkg

// ---- testbench/tts_ctrl_model.sv ----
`timescale 1ns/1ps
module tts_ctrl_model (
  // pacing clock
  input  wire logic clk_in,
  // resolved bus levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // open-drain pulls, high pulls the line low
  output logic      scl_low_out,
  output logic      sda_low_out
);
  localparam int HALF = 8;  // 40 ns half period of the bus clock
  // lines released at time zero
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // step n falling edges of the pacing clock
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  // one bus clock: set data while low, honour stretching, sample high
  task automatic pulse(input logic low, output logic smp);
    int w;
    tick(2);
    sda_low_out = low;
    tick(HALF - 2);
    scl_low_out = 1'b0;
    w = 0;
    while (scl_in !== 1'b1 && w < 20000) begin
      tick(1);
      w++;
    end
    tick(HALF / 2);
    smp = sda_in;
    tick(HALF / 2);
    scl_low_out = 1'b1;
  endtask : pulse
  // start: data falls while clock high, clock left low
  task automatic start_c;
    sda_low_out = 1'b0;
    scl_low_out = 1'b0;
    tick(HALF);
    sda_low_out = 1'b1;
    tick(HALF);
    scl_low_out = 1'b1;
  endtask : start_c
  // stop: data rises while clock high
  task automatic stop_c;
    tick(2);
    sda_low_out = 1'b1;
    tick(HALF);
    scl_low_out = 1'b0;
    tick(HALF);
    sda_low_out = 1'b0;
    tick(HALF);
  endtask : stop_c
  // send a byte msb first, return the target's ack bit
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(~b[i], s);
    end
    pulse(1'b0, ack);
  endtask : wr_byte
  // read a byte; collide pulls data low throughout the byte
  task automatic rd_byte(input logic nack, input logic collide, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(collide, b[i]);
    end
    pulse(~nack, s);
  endtask : rd_byte
endmodule : tts_ctrl_model

// ---- testbench/tts_target_bench.sv ----
`timescale 1ns/1ps
module tts_target_bench;
  import tts_pkg::*;
  localparam int LIMIT = 40000;  // cycle ceiling of the run
  logic       clk, rst_b;        // clock and reset
  logic [5:0] strb;              // buf_wr, buf_rd, addr_wr, release, irq_clr, coll_clr
  logic [5:0] cfg;               // ten, ahold, stretch, start_irq, coll_en, ack_val
  logic [7:0] wdat, dbuf, oaddr, rb;
  logic       scl_w, sda_w, m_scl, m_sda, scl_o, scl_oe, sda_o, sda_oe, ack;
  logic       crel, irq, bcol, ackst, ackt, rdir, dna, bfull, uaf, sseen;
  int         fail_count = 0, compares = 0, cyc = 0;
  // open-drain lines with pull-ups
  assign scl_w = ~(m_scl | scl_oe);
  assign sda_w = ~(m_sda | sda_oe);
  tts_target i_tts_target (
    .clk_in(clk), .rst_b_in(rst_b), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .buf_wr_in(strb[0]), .buf_wr_data_in(wdat), .buf_rd_in(strb[1]),
    .addr_wr_in(strb[2]), .addr_wr_data_in(wdat), .clock_release_set_in(strb[3]),
    .irq_clr_in(strb[4]), .collision_clr_in(strb[5]), .ten_bit_en_in(cfg[0]),
    .address_hold_en_in(cfg[1]), .stretch_enable_in(cfg[2]), .start_irq_en_in(cfg[3]),
    .target_collision_detect_en_in(cfg[4]), .ack_value_select_in(cfg[5]),
    .data_buffer_out(dbuf), .own_address_out(oaddr), .clock_release_out(crel),
    .port_irq_flag_out(irq), .bus_collision_flag_out(bcol),
    .ack_received_status_out(ackst), .ack_time_indicator_out(ackt),
    .read_dir_out(rdir), .data_not_addr_out(dna), .buffer_full_out(bfull),
    .update_address_flag_out(uaf), .start_seen_out(sseen));
  tts_ctrl_model i_tts_ctrl_model (
    .clk_in(clk), .scl_in(scl_w), .sda_in(sda_w), .scl_low_out(m_scl), .sda_low_out(m_sda));
  // clock and cycle ceiling
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end
  // one-cycle software strobe k with data d
  task automatic sw(input int k, input logic [7:0] d);
    @(negedge clk);
    strb[k] = 1'b1;
    wdat = d;
    @(negedge clk);
    strb = '0;
  endtask : sw
  // let synchroniser and flags settle
  task automatic settle;
    repeat (8) @(negedge clk);
  endtask : settle
  // compare one flag
  task automatic chk(input logic a, input logic e);
    compares++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, a, e);
    end
  endtask : chk
  // compare one byte
  task automatic chk8(input logic [7:0] a, input logic [7:0] e);
    compares++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] %0t byte %h expected %h", $time, a, e);
    end
  endtask : chk8
  // bounded wait for the interrupt flag
  task automatic wirq;
    int w;
    w = 0;
    while (irq !== 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
  endtask : wirq
  // read address under address hold, software answers at hold time
  task automatic hold_addr;
    fork
      i_tts_ctrl_model.wr_byte(8'ha5, ack);
      begin
        wirq();
        @(negedge clk);
        chk(ackt, 1'b1);
        chk(crel, 1'b0);
        chk(scl_oe, 1'b1);
        chk(rdir, 1'b1);
        sw(4, 8'h00);
        sw(3, 8'h00);
      end
    join
    settle();
  endtask : hold_addr
  // verdict and end of run
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    strb = '0;
    cfg = '0;
    wdat = '0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk(crel, 1'b1);
    chk(irq, 1'b0);
    chk(bfull, 1'b0);
    chk(scl_oe, 1'b0);
    chk(sda_oe, 1'b0);
    chk(scl_o, 1'b0);
    chk(sda_o, 1'b0);
    chk8(oaddr, 8'h00);
    $display("test reset done");
    // plain 7-bit read with start interrupt
    cfg = 6'h08;
    sw(2, 8'ha4);
    i_tts_ctrl_model.start_c();
    settle();
    chk(sseen, 1'b1);
    chk(irq, 1'b1);
    sw(4, 8'h00);
    i_tts_ctrl_model.wr_byte(8'ha5, ack);
    settle();
    chk(ack, 1'b0);
    chk(rdir, 1'b1);
    chk8(dbuf, 8'ha5);
    chk(irq, 1'b1);
    chk(crel, 1'b0);
    chk(scl_oe, 1'b1);
    sw(1, 8'h00);
    chk(bfull, 1'b0);
    sw(0, 8'h3c);
    chk(bfull, 1'b1);
    sw(4, 8'h00);
    sw(3, 8'h00);
    i_tts_ctrl_model.rd_byte(1'b0, 1'b0, rb);
    settle();
    chk8(rb, 8'h3c);
    chk(ackst, 1'b0);
    chk(irq, 1'b1);
    chk(scl_oe, 1'b1);
    sw(4, 8'h00);
    sw(0, 8'hc3);
    sw(3, 8'h00);
    i_tts_ctrl_model.rd_byte(1'b1, 1'b0, rb);
    settle();
    chk8(rb, 8'hc3);
    chk(ackst, 1'b1);
    chk(irq, 1'b1);
    chk(scl_oe, 1'b0);
    sw(4, 8'h00);
    i_tts_ctrl_model.rd_byte(1'b1, 1'b0, rb);
    settle();
    chk8(rb, 8'hff);
    chk(irq, 1'b0);
    i_tts_ctrl_model.stop_c();
    $display("test read done");
    // address hold, software refuses then accepts
    cfg = 6'h22;
    sw(4, 8'h00);
    i_tts_ctrl_model.start_c();
    settle();
    chk(sseen, 1'b1);
    chk(irq, 1'b0);
    hold_addr();
    chk(ack, 1'b1);
    chk(irq, 1'b0);
    i_tts_ctrl_model.stop_c();
    cfg = 6'h02;
    i_tts_ctrl_model.start_c();
    hold_addr();
    chk(ack, 1'b0);
    chk(irq, 1'b1);
    chk(crel, 1'b0);
    sw(4, 8'h00);
    sw(0, 8'h5a);
    sw(3, 8'h00);
    i_tts_ctrl_model.rd_byte(1'b1, 1'b0, rb);
    chk8(rb, 8'h5a);
    i_tts_ctrl_model.stop_c();
    $display("test hold done");
    // collision while sending ones
    cfg = 6'h10;
    i_tts_ctrl_model.start_c();
    i_tts_ctrl_model.wr_byte(8'ha5, ack);
    settle();
    sw(0, 8'hff);
    sw(3, 8'h00);
    i_tts_ctrl_model.rd_byte(1'b1, 1'b1, rb);
    settle();
    chk(bcol, 1'b1);
    chk(sda_oe, 1'b0);
    sw(5, 8'h00);
    chk(bcol, 1'b0);
    i_tts_ctrl_model.stop_c();
    $display("test collision done");
    // 10-bit write: low mismatch, then full match with stretching
    cfg = 6'h01;
    sw(2, 8'hf6);
    sw(4, 8'h00);
    i_tts_ctrl_model.start_c();
    i_tts_ctrl_model.wr_byte(8'hf6, ack);
    settle();
    chk(ack, 1'b0);
    chk(uaf, 1'b1);
    chk(irq, 1'b1);
    chk(scl_oe, 1'b1);
    sw(1, 8'h00);
    sw(4, 8'h00);
    sw(2, 8'h5a);
    chk(uaf, 1'b0);
    i_tts_ctrl_model.wr_byte(8'h77, ack);
    settle();
    chk(uaf, 1'b1);
    chk(irq, 1'b1);
    chk(bfull, 1'b0);
    chk(crel, 1'b1);
    sw(2, 8'hf6);
    i_tts_ctrl_model.stop_c();
    cfg = 6'h05;
    i_tts_ctrl_model.start_c();
    i_tts_ctrl_model.wr_byte(8'hf6, ack);
    settle();
    sw(2, 8'h5a);
    i_tts_ctrl_model.wr_byte(8'h5a, ack);
    settle();
    chk(ack, 1'b0);
    chk(uaf, 1'b1);
    chk(bfull, 1'b1);
    sw(1, 8'h00);
    sw(4, 8'h00);
    sw(2, 8'hf6);
    i_tts_ctrl_model.wr_byte(8'h81, ack);
    settle();
    chk8(dbuf, 8'h81);
    chk(dna, 1'b1);
    chk(irq, 1'b1);
    chk(crel, 1'b0);
    chk(scl_oe, 1'b1);
    sw(3, 8'h00);
    settle();
    chk(scl_oe, 1'b0);
    i_tts_ctrl_model.stop_c();
    $display("test ten bit done");
    conclude();
  end
endmodule : tts_target_bench
